// *** rtl/dmhs_pkg.sv ***
// Constants, register map and carrier types of the diagnostic mux and Hall sense block.
// Assumes a 25 MHz mclk and an Avalon-MM byte-addressed register port.
//
// Overview of operation
// - Four-bit read/write channel selector in bits 3..0, upper bits zero, reset clears.
// - Codes 0-3 bridge sense, 4 supply prescaler, 5 temperature, 7 analog pin.
// - Current source on only when power-stage enable and source enable both set.
// - Two-bit level field picks 10, 30, 60 or 100 percent strength.
// - Current source forced off during STOP mode.
// - Auxiliary supply enable bit switches the auxiliary supply output; reset clears.
// - Lamp driver enable bit switches the high-side lamp driver; reset clears.
// - Hall inputs ignore the power-stage enable bit.
// - Per-input enable bits 2..0 power each Hall sensor and its sensing.
// - Hall flag set above threshold, with hysteresis against noise.
// - Low Hall output voltage while any Hall input is powered sets the Hall over-current flag.
// - In RUN any Hall flag change sets the change flag; mask gates request.
// - In STOP the Hall inputs stay disabled outside a cyclic check, whatever their enable bits.
// - Cyclic check powers enabled inputs periodically, samples after 40 us.
// - Cyclic hit on any enabled input, with cyclic check and Hall interrupt enables set, raises interrupt, wake and regulator start.
// - Hall control bits 7..3 read zero; reset clears the enable bits.
// - Interrupt mask bit 6 is the Hall interrupt enable; reset clears.
// - Hall flags follow inputs only while enabled; reset clears them.

package dmhs_pkg;

    // ----------------------------------------
    // Register indices (byte address = 4 * index)
    // ----------------------------------------
    localparam logic [3:0] IDX_INT_MASK = 4'h4;
    localparam logic [3:0] IDX_DIAG_SEL = 4'h7;
    localparam logic [3:0] IDX_HALL_CTL = 4'h8;
    localparam logic [3:0] IDX_HALL_STAT = 4'h9;
    localparam logic [3:0] IDX_POWER_OUT = 4'hB;
    localparam logic [3:0] IDX_SYS_CTL = 4'hC;
    localparam logic [3:0] IDX_SYS_STAT = 4'hD;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int POS_SRC_LEVEL = 4;
    localparam int POS_SRC_ENABLE = 3;
    localparam int POS_AUX_SUPPLY_ON = 1;
    localparam int POS_LAMP_DRIVER_ON = 0;
    localparam int POS_HALL_IRQ_ENABLE = 6;
    localparam int POS_HALL_CHANGE_FLAG = 4;
    localparam int POS_POWER_STAGE_ENABLE = 0;
    localparam int POS_CYCLIC_CHECK_ENABLE = 1;
    localparam int POS_HALL_OVERCURRENT_FLAG = 0;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [3:0] RST_DIAG_SEL = 4'h0;
    localparam logic [2:0] RST_HALL_EN = 3'h0;
    localparam logic [7:0] RST_BYTE = 8'h00;

    // ----------------------------------------
    // Selector codes
    // ----------------------------------------
    localparam logic [3:0] SEL_SUPPLY_PRESCALER = 4'h4;
    localparam logic [3:0] SEL_TEMP_SENSOR = 4'h5;
    localparam logic [3:0] SEL_ANALOG_PIN = 4'h7;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int MCLK_KHZ = 25000;
    localparam int HALL_SETTLE_US = 40;
    localparam int HALL_SETTLE_CYC = (HALL_SETTLE_US * MCLK_KHZ + 999) / 1000;
    localparam int SETTLE_W = 10;

    // ----------------------------------------
    // Carrier types
    // ----------------------------------------
    typedef struct packed {
        logic [3:0] hb_sense;
        logic supply_prescaler;
        logic temp_sensor;
        logic analog_pin;
    } dmhs_route_t;

    typedef struct packed {
        logic [1:0] src_level;
        logic src_enable;
        logic aux_supply_on;
        logic lamp_driver_on;
    } dmhs_power_output_control_t;

    typedef enum logic [2:0] {
        CYC_IDLE = 3'b001,
        CYC_SETTLE = 3'b010,
        CYC_SAMPLE = 3'b100
    } dmhs_cyc_t;

endpackage : dmhs_pkg

// *** rtl/dmhs_hall_chan.sv ***
// One Hall sense channel: flag with hysteresis from two comparator levels.
// Assumes the comparators are synchronous to mclk and never both high.
`timescale 1ns/1ns

module dmhs_hall_chan (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Channel control and sense
    input wire logic sense_active,
    input wire logic sense_hi,
    input wire logic sense_lo,
    // Result
    output logic flag_q
);
    import dmhs_pkg::*;

    logic flag_d;

    // ----------------------------------------
    // Hysteresis flag
    // ----------------------------------------
    // Set above upper level, clear below lower, hold in between or when idle
    always_comb begin
        flag_d = flag_q;
        if (sense_active) begin
            if (sense_hi) begin
                flag_d = 1'b1;
            end else if (sense_lo) begin
                flag_d = 1'b0;
            end
        end
    end

    // Flag register
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    AST_FLAG_HOLD_IDLE: assert property (@(posedge mclk) disable iff (!reset_n)
        !sense_active |=> $stable(flag_q))
        else $error("hall flag moved while channel inactive");

    AST_FLAG_HYST: assert property (@(posedge mclk) disable iff (!reset_n)
        (sense_active && !sense_hi && !sense_lo) |=> $stable(flag_q))
        else $error("hall flag moved inside hysteresis band");

endmodule : dmhs_hall_chan

// *** rtl/dmhs_ctrl.sv ***
// Diagnostic selector, analog source, power outputs and Hall sense control.
// Assumes an Avalon-MM master on mclk, STOP and watchdog tick from the system.
`timescale 1ns/1ns

module dmhs_ctrl (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Avalon-MM slave
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // System state
    input wire logic stop_mode,
    input wire logic wdog_cycle_tick,
    input wire logic hall_supply_low,
    // Hall comparators
    input wire logic [2:0] hall_sense_hi,
    input wire logic [2:0] hall_sense_lo,
    // Analog routing and source
    output dmhs_pkg::dmhs_route_t diag_route,
    output logic src_on,
    output logic [1:0] src_level,
    // Power outputs
    output logic aux_supply_output,
    output logic lamp_driver_out,
    output logic [2:0] hall_power,
    // Requests
    output logic irq,
    output logic wake_request,
    output logic regulator_start
);
    import dmhs_pkg::*;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    logic wr_acc;
    logic [3:0] idx;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    logic [3:0] sel_q, sel_d;
    logic [2:0] hall_en_q, hall_en_d;
    dmhs_power_output_control_t power_output_control_q, power_output_control_d;
    logic irq_en_q, irq_en_d;
    logic pse_q, pse_d;
    logic cce_q, cce_d;
    logic ocf_q, ocf_d;
    logic chg_q, chg_d;
    logic [2:0] flags;
    logic [2:0] flags_prev_q;
    logic run_change;
    dmhs_cyc_t cyc_q, cyc_d;
    logic [SETTLE_W-1:0] cnt_q, cnt_d;
    logic cyc_hit;
    logic [2:0] hpow_d;
    dmhs_route_t route_d;
    logic src_on_d;
    logic wake_d;

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    // One wait cycle per access; write lands and read data stands on ack
    assign idx = avs_address[5:2];
    assign wbyte = avs_writedata[7:0];
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    assign wr_acc = avs_write & ack_q & avs_byteenable[0];
    assign avs_readdata = rdata_q;

    // Read mux, unmapped reads zero
    always_comb begin
        rbyte = RST_BYTE;
        unique case (idx)
            IDX_DIAG_SEL: rbyte = {4'h0, sel_q};
            IDX_HALL_CTL: rbyte = {5'h00, hall_en_q};
            IDX_HALL_STAT: begin
                rbyte[2:0] = flags;
                rbyte[POS_HALL_CHANGE_FLAG] = chg_q;
            end
            IDX_POWER_OUT: begin
                rbyte[POS_SRC_LEVEL +: 2] = power_output_control_q.src_level;
                rbyte[POS_SRC_ENABLE] = power_output_control_q.src_enable;
                rbyte[POS_AUX_SUPPLY_ON] = power_output_control_q.aux_supply_on;
                rbyte[POS_LAMP_DRIVER_ON] = power_output_control_q.lamp_driver_on;
            end
            IDX_INT_MASK: rbyte[POS_HALL_IRQ_ENABLE] = irq_en_q;
            IDX_SYS_CTL: begin
                rbyte[POS_POWER_STAGE_ENABLE] = pse_q;
                rbyte[POS_CYCLIC_CHECK_ENABLE] = cce_q;
            end
            IDX_SYS_STAT: rbyte[POS_HALL_OVERCURRENT_FLAG] = ocf_q;
            default: rbyte = RST_BYTE;
        endcase
    end

    // Handshake and read capture
    always_comb begin
        ack_d = (avs_read | avs_write) & ~ack_q;
        rdata_d = rdata_q;
        if (avs_read && !ack_q) begin
            rdata_d = {24'h000000, rbyte};
        end
    end

    // Bus registers
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    // Software writes; power output bit 2 is not stored and reads zero
    always_comb begin
        sel_d = sel_q;
        hall_en_d = hall_en_q;
        power_output_control_d = power_output_control_q;
        irq_en_d = irq_en_q;
        pse_d = pse_q;
        cce_d = cce_q;
        if (wr_acc) begin
            unique case (idx)
                IDX_DIAG_SEL: sel_d = wbyte[3:0];
                IDX_HALL_CTL: hall_en_d = wbyte[2:0];
                IDX_POWER_OUT: begin
                    power_output_control_d.src_level = wbyte[POS_SRC_LEVEL +: 2];
                    power_output_control_d.src_enable = wbyte[POS_SRC_ENABLE];
                    power_output_control_d.aux_supply_on = wbyte[POS_AUX_SUPPLY_ON];
                    power_output_control_d.lamp_driver_on = wbyte[POS_LAMP_DRIVER_ON];
                end
                IDX_INT_MASK: irq_en_d = wbyte[POS_HALL_IRQ_ENABLE];
                IDX_SYS_CTL: begin
                    pse_d = wbyte[POS_POWER_STAGE_ENABLE];
                    cce_d = wbyte[POS_CYCLIC_CHECK_ENABLE];
                end
                default: sel_d = sel_q;
            endcase
        end
    end

    // Control register bank
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            sel_q <= RST_DIAG_SEL;
            hall_en_q <= RST_HALL_EN;
            power_output_control_q <= '0;
            irq_en_q <= 1'b0;
            pse_q <= 1'b0;
            cce_q <= 1'b0;
        end else begin
            sel_q <= sel_d;
            hall_en_q <= hall_en_d;
            power_output_control_q <= power_output_control_d;
            irq_en_q <= irq_en_d;
            pse_q <= pse_d;
            cce_q <= cce_d;
        end
    end

    // ----------------------------------------
    // Hall channels
    // ----------------------------------------
    // Flags update only while powered in RUN mode
    generate
        for (genvar ch = 0; ch < 3; ch++) begin : g_hall
            dmhs_hall_chan u_chan (
                .mclk(mclk),
                .reset_n(reset_n),
                .sense_active(hall_power[ch] & ~stop_mode),
                .sense_hi(hall_sense_hi[ch]),
                .sense_lo(hall_sense_lo[ch]),
                .flag_q(flags[ch])
            );
        end
    endgenerate

    // ----------------------------------------
    // Cyclic check sequencer
    // ----------------------------------------
    // Watchdog tick powers enabled inputs, waits settle time, samples once
    assign cyc_hit = |(hall_sense_hi & hall_en_q) & cce_q & irq_en_q;

    always_comb begin
        cyc_d = cyc_q;
        cnt_d = cnt_q;
        unique case (cyc_q)
            CYC_IDLE: begin
                cnt_d = '0;
                if (wdog_cycle_tick && stop_mode && cce_q && (|hall_en_q)) begin
                    cyc_d = CYC_SETTLE;
                end
            end
            CYC_SETTLE: begin
                cnt_d = cnt_q + SETTLE_W'(1);
                if (cnt_q == SETTLE_W'(HALL_SETTLE_CYC - 1)) begin
                    cyc_d = CYC_SAMPLE;
                end
            end
            CYC_SAMPLE: cyc_d = CYC_IDLE;
            default: cyc_d = CYC_IDLE;
        endcase
        if (!stop_mode) begin
            cyc_d = CYC_IDLE;
        end
    end

    // Sequencer registers
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cyc_q <= CYC_IDLE;
            cnt_q <= '0;
        end else begin
            cyc_q <= cyc_d;
            cnt_q <= cnt_d;
        end
    end

    // ----------------------------------------
    // Flags and requests
    // ----------------------------------------
    // Change detect in RUN, cyclic hit in STOP; a set beats a clear
    assign run_change = (flags != flags_prev_q) & ~stop_mode;
    assign wake_d = (cyc_q == CYC_SAMPLE) & cyc_hit;

    always_comb begin
        chg_d = chg_q;
        ocf_d = ocf_q;
        if (wr_acc && idx == IDX_HALL_STAT && wbyte[POS_HALL_CHANGE_FLAG]) begin
            chg_d = 1'b0;
        end
        if (wr_acc && idx == IDX_SYS_STAT && wbyte[POS_HALL_OVERCURRENT_FLAG]) begin
            ocf_d = 1'b0;
        end
        if (run_change || wake_d) begin
            chg_d = 1'b1;
        end
        if (hall_supply_low && (|hall_power)) begin
            ocf_d = 1'b1;
        end
    end

    // Flag and request registers
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            chg_q <= 1'b0;
            ocf_q <= 1'b0;
            flags_prev_q <= 3'h0;
            wake_request <= 1'b0;
            regulator_start <= 1'b0;
        end else begin
            chg_q <= chg_d;
            ocf_q <= ocf_d;
            flags_prev_q <= flags;
            wake_request <= wake_d;
            regulator_start <= wake_d;
        end
    end

    // Masked interrupt request
    assign irq = chg_q & irq_en_q;

    // ----------------------------------------
    // Analog and power outputs
    // ----------------------------------------
    // Decode selector; unused codes route nothing
    always_comb begin
        route_d = '0;
        if (sel_q[3:2] == 2'b00) begin
            route_d.hb_sense[sel_q[1:0]] = 1'b1;
        end
        route_d.supply_prescaler = (sel_q == SEL_SUPPLY_PRESCALER);
        route_d.temp_sensor = (sel_q == SEL_TEMP_SENSOR);
        route_d.analog_pin = (sel_q == SEL_ANALOG_PIN);
        src_on_d = pse_q & power_output_control_q.src_enable & ~stop_mode;
        hpow_d = stop_mode ? ((cyc_q != CYC_IDLE) ? hall_en_q : 3'h0) : hall_en_q;
    end

    // Output registers
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            diag_route <= '0;
            src_on <= 1'b0;
            src_level <= 2'h0;
            aux_supply_output <= 1'b0;
            lamp_driver_out <= 1'b0;
            hall_power <= 3'h0;
        end else begin
            diag_route <= route_d;
            src_on <= src_on_d;
            src_level <= power_output_control_q.src_level;
            aux_supply_output <= power_output_control_q.aux_supply_on;
            lamp_driver_out <= power_output_control_q.lamp_driver_on;
            hall_power <= hpow_d;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_cyc_start;
        (cyc_q == CYC_IDLE) && wdog_cycle_tick && stop_mode && cce_q && (|hall_en_q);
    endsequence

    sequence s_cyc_settle;
        (cyc_q == CYC_SETTLE) [*8];
    endsequence

    AST_SEL_PRESCALER: assert property (@(posedge mclk) disable iff (!reset_n)
        (sel_q == 4'h4) |=> diag_route.supply_prescaler && diag_route.hb_sense == 4'h0)
        else $error("prescaler not routed for code 4");

    AST_SEL_UNUSED: assert property (@(posedge mclk) disable iff (!reset_n)
        (sel_q == 4'h6 || sel_q[3]) |=> (diag_route == '0))
        else $error("unused selector code routed a source");

    AST_SEL_READ: assert property (@(posedge mclk) disable iff (!reset_n)
        (avs_read && ack_q && idx == IDX_DIAG_SEL) |-> avs_readdata[31:4] == 28'h0)
        else $error("selector upper bits not zero");

    AST_SRC_GATE: assert property (@(posedge mclk) disable iff (!reset_n)
        src_on |-> $past(pse_q) && $past(power_output_control_q.src_enable) && !$past(stop_mode))
        else $error("current source on without both enables");

    AST_SRC_STOP: assert property (@(posedge mclk) disable iff (!reset_n)
        stop_mode [*2] |-> !src_on)
        else $error("current source on in stop mode");

    AST_HALL_STOP: assert property (@(posedge mclk) disable iff (!reset_n)
        (stop_mode && cyc_q == CYC_IDLE) [*2] |-> hall_power == 3'h0)
        else $error("hall input powered in stop outside cyclic check");

    AST_HALL_PSE: assert property (@(posedge mclk) disable iff (!reset_n)
        (!stop_mode && !pse_q) |=> hall_power == $past(hall_en_q))
        else $error("hall power gated by power stage enable");

    AST_CHG_SET: assert property (@(posedge mclk) disable iff (!reset_n)
        run_change |=> chg_q)
        else $error("hall change flag not set on state change");

    AST_CHG_W1C: assert property (@(posedge mclk) disable iff (!reset_n)
        (wr_acc && idx == IDX_HALL_STAT && wbyte[POS_HALL_CHANGE_FLAG] && !run_change
        && !wake_d) |=> !chg_q)
        else $error("write one did not clear hall change flag");

    AST_CYC_SETTLE: assert property (@(posedge mclk) disable iff (!reset_n)
        s_cyc_start ##1 (stop_mode [*8]) |-> s_cyc_settle)
        else $error("cyclic check did not hold settle state");

    AST_CYC_CNT: assert property (@(posedge mclk) disable iff (!reset_n)
        (cyc_q == CYC_SAMPLE) |-> $past(cnt_q) == SETTLE_W'(HALL_SETTLE_CYC - 1))
        else $error("cyclic sample not at settle count");

    AST_CYC_WAKE: assert property (@(posedge mclk) disable iff (!reset_n)
        (cyc_q == CYC_SAMPLE && cyc_hit) |=> wake_request && regulator_start && irq)
        else $error("cyclic hit did not wake");

    AST_OCF: assert property (@(posedge mclk) disable iff (!reset_n)
        (hall_supply_low && (|hall_power)) |=> ocf_q)
        else $error("hall overcurrent flag not set");

endmodule : dmhs_ctrl

// *** tb/dmhs_hall_model.sv ***
// Three two-pin Hall sensors seen through their upper and lower comparators.
// Assumes the bench sets each channel current: 0 low, 1 between, 2 high.
`timescale 1ns/1ns

module dmhs_hall_model (
    // Clock
    input wire logic mclk,
    // Sensor power and current
    input wire logic [2:0] hall_power,
    input wire logic [5:0] cur,
    // Comparator outputs
    output logic [2:0] sense_hi,
    output logic [2:0] sense_lo
);
    // Unpowered sensor draws no current, so it reads as below threshold
    always_ff @(posedge mclk) begin
        for (int i = 0; i < 3; i++) begin
            sense_hi[i] <= hall_power[i] && cur[2*i+:2] == 2'h2;
            sense_lo[i] <= !hall_power[i] || cur[2*i+:2] == 2'h0;
        end
    end
endmodule : dmhs_hall_model

// *** tb/dmhs_ctrl_test.sv ***
// Self-checking bench of the diagnostic mux and Hall sense block.
// Assumes the package register map and one-wait-cycle Avalon-MM slave.
`timescale 1ns/1ns

module dmhs_ctrl_test;
    import dmhs_pkg::*;

    // ----------------
    // Signals
    // ----------------
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic [5:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic stop_mode = 1'b0;
    logic tick = 1'b0;
    logic supply_low = 1'b0;
    logic [5:0] cur = '0;
    logic [2:0] s_hi, s_lo, hall_power;
    dmhs_route_t diag_route;
    logic src_on, aux, lamp, irq, wake, reg_start;
    logic [1:0] src_level;
    logic [7:0] q;
    int error_cnt = 0;
    int n_tests = 0;
    int n;

    // Clock
    initial begin
        forever #20 mclk = ~mclk;
    end

    // Design and sensor model
    dmhs_ctrl i_dut (
        .mclk(mclk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .stop_mode(stop_mode), .wdog_cycle_tick(tick),
        .hall_supply_low(supply_low), .hall_sense_hi(s_hi), .hall_sense_lo(s_lo),
        .diag_route(diag_route), .src_on(src_on), .src_level(src_level),
        .aux_supply_output(aux), .lamp_driver_out(lamp), .hall_power(hall_power),
        .irq(irq), .wake_request(wake), .regulator_start(reg_start)
    );
    dmhs_hall_model i_hall (
        .mclk(mclk), .hall_power(hall_power), .cur(cur), .sense_hi(s_hi), .sense_lo(s_lo)
    );

    // ----------------
    // Tasks
    // ----------------
    task automatic end_of_test;
        if (error_cnt == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    // One bus cycle, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] idx, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge mclk);
        avs_address <= {idx, 2'b00};
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h0, d};
        #1;
        while (avs_waitrequest !== 1'b0) begin
            k++;
            if (k > 50) begin
                error_cnt++;
                end_of_test();
            end
            @(posedge mclk);
            #1;
        end
        @(posedge mclk);
        q = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus

    task automatic rd(input logic [3:0] idx, input logic [7:0] e);
        bus(1'b0, idx, 8'h00);
        check(q, e);
    endtask : rd

    task automatic cyc(input int c);
        repeat (c) @(posedge mclk);
        #1;
    endtask : cyc

    function automatic logic [6:0] route(input int c);
        route = {(c < 4) ? 4'h1 << c : 4'h0, c == 4, c == 5, c == 7};
    endfunction : route

    // Main sequence
    initial begin
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        rd(IDX_DIAG_SEL, 8'h00);
        rd(IDX_HALL_CTL, 8'h00);
        rd(IDX_POWER_OUT, 8'h00);
        rd(IDX_INT_MASK, 8'h00);
        bus(1'b1, 4'hE, 8'hFF);
        rd(4'hE, 8'h00);
        for (int c = 0; c < 16; c++) begin
            bus(1'b1, IDX_DIAG_SEL, 8'hF0 | c[7:0]);
            cyc(2);
            rd(IDX_DIAG_SEL, c[7:0]);
            check(8'(diag_route), 8'(route(c)));
        end
        avs_byteenable <= 4'hE;
        bus(1'b1, IDX_DIAG_SEL, 8'h05);
        avs_byteenable <= 4'hF;
        rd(IDX_DIAG_SEL, 8'h0F);
        bus(1'b1, IDX_POWER_OUT, 8'hFB);
        cyc(2);
        rd(IDX_POWER_OUT, 8'h3B);
        check(8'(aux), 8'h01);
        check(8'(lamp), 8'h01);
        for (int l = 0; l < 4; l++) begin
            bus(1'b1, IDX_POWER_OUT, 8'h08 | 8'(l << 4));
            cyc(2);
            check(8'(src_level), 8'(l));
        end
        check(8'(aux), 8'h00);
        check(8'(lamp), 8'h00);
        check(8'(src_on), 8'h00);
        bus(1'b1, IDX_SYS_CTL, 8'h01);
        cyc(2);
        check(8'(src_on), 8'h01);
        @(posedge mclk);
        stop_mode <= 1'b1;
        cyc(2);
        check(8'(src_on), 8'h00);
        @(posedge mclk);
        stop_mode <= 1'b0;
        bus(1'b1, IDX_POWER_OUT, 8'h30);
        cyc(2);
        check(8'(src_on), 8'h00);
        bus(1'b1, IDX_SYS_CTL, 8'h00);
        cur <= 6'h0A;
        bus(1'b1, IDX_HALL_CTL, 8'hF9);
        cyc(2);
        check(8'(hall_power), 8'h01);
        rd(IDX_HALL_CTL, 8'h01);
        cyc(HALL_SETTLE_CYC);
        rd(IDX_HALL_STAT, 8'h11);
        check(8'(irq), 8'h00);
        bus(1'b1, IDX_HALL_STAT, 8'h10);
        bus(1'b1, IDX_INT_MASK, 8'h40);
        rd(IDX_INT_MASK, 8'h40);
        rd(IDX_HALL_STAT, 8'h01);
        cur <= 6'h09;
        cyc(4);
        rd(IDX_HALL_STAT, 8'h01);
        cur <= 6'h08;
        cyc(4);
        check(8'(irq), 8'h01);
        bus(1'b1, IDX_HALL_STAT, 8'h00);
        rd(IDX_HALL_STAT, 8'h10);
        bus(1'b1, IDX_HALL_STAT, 8'h10);
        cyc(1);
        check(8'(irq), 8'h00);
        @(posedge mclk);
        stop_mode <= 1'b1;
        cyc(2);
        check(8'(hall_power), 8'h00);
        @(posedge mclk);
        stop_mode <= 1'b0;
        supply_low <= 1'b1;
        cyc(4);
        @(posedge mclk);
        supply_low <= 1'b0;
        rd(IDX_SYS_STAT, 8'h01);
        bus(1'b1, IDX_SYS_STAT, 8'h01);
        rd(IDX_SYS_STAT, 8'h00);
        cur <= 6'h20;
        bus(1'b1, IDX_HALL_CTL, 8'h04);
        bus(1'b1, IDX_SYS_CTL, 8'h02);
        cyc(10);
        bus(1'b1, IDX_HALL_STAT, 8'h10);
        stop_mode <= 1'b1;
        cyc(3);
        check(8'(irq), 8'h00);
        @(posedge mclk);
        tick <= 1'b1;
        @(posedge mclk);
        tick <= 1'b0;
        n = 0;
        while (wake !== 1'b1) begin
            cyc(1);
            n++;
            if (n == 500) check(8'(hall_power), 8'h04);
            if (n > 1100) begin
                error_cnt++;
                end_of_test();
            end
        end
        check(8'(reg_start), 8'h01);
        check(8'(n >= HALL_SETTLE_CYC && n <= HALL_SETTLE_CYC + 2), 8'h01);
        check(8'(irq), 8'h01);
        @(posedge mclk);
        stop_mode <= 1'b0;
        end_of_test();
    end
endmodule : dmhs_ctrl_test
